// File: src/adcc_pkg.sv
// Purpose: shared constants for the converter sequencing and conflict controller
// Assumes: classic wishbone slave, 32-bit data, byte addresses
// Notes: 8-bit registers sit in the low byte of each word
package adcc_pkg;
	// ==========================
	// register map
	localparam logic [3:0] ADCC_OFS_MODE = 4'h0;
	localparam logic [3:0] ADCC_OFS_SEL = 4'h4;
	localparam logic [3:0] ADCC_OFS_RESULT = 4'h8;
	localparam logic [3:0] ADCC_OFS_STATUS = 4'hC;
	localparam logic [3:0] ADCC_OFS_MASK = 4'h0;
	localparam logic [7:0] ADCC_MODE_RST = 8'h00;
	localparam logic [7:0] ADCC_SEL_RST = 8'h00;
	// field positions
	localparam int ADCC_EN_BIT = 7;
	localparam int ADCC_FR_LO = 3;
	localparam int ADCC_SEL_BIT = 0;
	localparam int ADCC_ST_DONE = 0;
	localparam int ADCC_ST_FIRST = 1;
	localparam int ADCC_ST_DROP = 2;
	localparam logic [7:0] ADCC_MODE_WMASK = 8'hB8;
	// timing: conversion time selections in main clock cycles
	localparam logic [2:0] ADCC_FR_72 = 3'h0;
	localparam logic [2:0] ADCC_FR_60 = 3'h1;
	localparam logic [2:0] ADCC_FR_48 = 3'h2;
	localparam logic [2:0] ADCC_FR_144 = 3'h4;
	localparam logic [2:0] ADCC_FR_120 = 3'h5;
	localparam logic [2:0] ADCC_FR_96 = 3'h6;
	localparam logic [7:0] ADCC_SAMPLE_DIV = 8'h0A;
	localparam int ADCC_NBITS = 8;

	typedef enum logic [3:0] {
		ADCC_IDLE = 4'b0001,
		ADCC_SAMPLE = 4'b0010,
		ADCC_CONVERT = 4'b0100,
		ADCC_DONE = 4'b1000
	} adcc_state_e;

	// conversion time in cycles for a selection; unknown codes fall to slowest
	function automatic logic [7:0] adcc_conv_cycles(input logic [2:0] fr);
		case (fr)
			ADCC_FR_72: adcc_conv_cycles = 8'h48;
			ADCC_FR_60: adcc_conv_cycles = 8'h3C;
			ADCC_FR_48: adcc_conv_cycles = 8'h30;
			ADCC_FR_144: adcc_conv_cycles = 8'h90;
			ADCC_FR_120: adcc_conv_cycles = 8'h78;
			ADCC_FR_96: adcc_conv_cycles = 8'h60;
			default: adcc_conv_cycles = 8'h90;
		endcase
	endfunction
endpackage

// File: src/adcc_core_if.sv
`timescale 1ns/1ps
// Purpose: link between sequencer and successive approximation core
// Assumes: single clock
// Notes: comparator result is sampled once per bit step
interface adcc_core_if;
	logic sample;
	logic hold;
	logic [7:0] trial;
	logic cmp_hi;
	modport seq(output sample, output hold, output trial, input cmp_hi);
	modport sar(input sample, input hold, input trial, output cmp_hi);
endinterface

// File: src/adcc_sar.sv
`timescale 1ns/1ps
// Purpose: bit-by-bit successive approximation from the top bit down
// Assumes: comparator high means input at or above trial tap
// Notes: restart reloads the top bit and clears the rest
module adcc_sar
	import adcc_pkg::*;
#(
	parameter int NBITS = ADCC_NBITS
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// control
	input wire logic start_i,
	input wire logic step_i,
	input wire logic cmp_hi_i,
	// trial value and result
	output logic [NBITS-1:0] trial_o,
	output logic last_o
);
	logic [NBITS-1:0] trial_reg;
	logic [NBITS-1:0] bit_reg;

	assign trial_o = trial_reg;
	assign last_o = bit_reg[0];

	// ==========================
	// approximation steps
	always_ff @(posedge clk_i) begin
		if (rst_i || start_i) begin
			trial_reg <= {1'b1, {(NBITS-1){1'b0}}};
			bit_reg <= {1'b1, {(NBITS-1){1'b0}}};
		end else if (step_i && (bit_reg != '0)) begin
			// keep or drop current bit, then try the next one
			trial_reg <= (cmp_hi_i ? trial_reg : (trial_reg & ~bit_reg)) | (bit_reg >> 1);
			bit_reg <= bit_reg >> 1;
		end
	end
endmodule

// File: src/adcc_ctrl.sv
`timescale 1ns/1ps
// Contract
// - standby stops all conversion activity at once
// - result read colliding with update: read first, then store
// - mode or select write beats result update; no update, no done event
// - first result after starting is undefined
// - sampling takes about a tenth of the conversion time
// - mode write leaves the done flag unchanged
// - after mode write, result and flag may still show the old input
// - setting enable starts converting the selected analog input
// - each completion latches the result and raises done
// - conversions repeat until mode register is written again
// - mode write with enable restarts; without enable stops
//
// Purpose: sequencing and collision control for an 8-bit converter
// Assumes: wishbone classic slave; ack one cycle after strobe
// Notes: status register is cleared by reading it; 0x10 is the mask
module adcc_ctrl
	import adcc_pkg::*;
#(
	parameter int NBITS = ADCC_NBITS
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [4:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// analog core
	input wire logic cmp_hi_i,
	output logic sample_o,
	output logic [NBITS-1:0] trial_o,
	output logic analog_sel_o,
	// system
	input wire logic standby_i,
	output logic irq_o,
	output logic conversion_done_irq_o
);
	adcc_core_if core ();
	adcc_state_e state_reg, state_next;
	logic [7:0] converter_mode_reg;
	logic [7:0] input_select_reg;
	logic [NBITS-1:0] conversion_result_reg;
	logic [NBITS-1:0] pending_reg;
	logic pending_valid_reg;
	logic [2:0] status_reg;
	logic [2:0] mask_reg;
	logic [7:0] cnt_reg;
	logic [7:0] step_len_reg;
	logic first_reg;
	logic ack_reg;
	logic [31:0] dat_reg;
	logic irq_reg;
	logic done_irq_reg;
	logic sample_reg;
	logic [NBITS-1:0] trial_reg;
	logic sel_reg;
	logic bus_req;
	logic wr_mode;
	logic wr_sel;
	logic wr_mask;
	logic rd_result;
	logic rd_status;
	logic ctrl_write;
	logic conv_enable_bit;
	logic sar_start;
	logic sar_step;
	logic sar_last;
	logic conv_end;
	logic store_now;
	logic [7:0] conv_len;
	logic [7:0] sample_len;

	// ==========================
	// bus decode
	function automatic logic hit(input logic [4:0] a, input logic [3:0] ofs, input logic hi);
		hit = (a[4] == hi) && (a[3:0] == ofs);
	endfunction

	assign bus_req = cyc_i && stb_i && !ack_reg;
	assign wr_mode = bus_req && we_i && sel_i[0] && hit(adr_i, ADCC_OFS_MODE, 1'b0);
	assign wr_sel = bus_req && we_i && sel_i[0] && hit(adr_i, ADCC_OFS_SEL, 1'b0);
	assign wr_mask = bus_req && we_i && sel_i[0] && hit(adr_i, ADCC_OFS_MASK, 1'b1);
	assign rd_result = bus_req && !we_i && hit(adr_i, ADCC_OFS_RESULT, 1'b0);
	assign rd_status = bus_req && !we_i && hit(adr_i, ADCC_OFS_STATUS, 1'b0);
	assign ctrl_write = wr_mode || wr_sel;
	assign conv_enable_bit = converter_mode_reg[ADCC_EN_BIT];
	assign conv_len = adcc_conv_cycles(converter_mode_reg[ADCC_FR_LO +: 3]);
	// the tenth is rounded down but never below one cycle
	assign sample_len = ((conv_len / ADCC_SAMPLE_DIV) == 8'h00) ? 8'h01 : (conv_len / ADCC_SAMPLE_DIV);

	// ==========================
	// registers written by software
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			converter_mode_reg <= ADCC_MODE_RST;
			input_select_reg <= ADCC_SEL_RST;
			mask_reg <= '0;
		end else begin
			if (wr_mode) begin
				converter_mode_reg <= dat_i[7:0] & ADCC_MODE_WMASK;
			end
			if (wr_sel) begin
				input_select_reg <= {7'h00, dat_i[ADCC_SEL_BIT]};
			end
			if (wr_mask) begin
				mask_reg <= dat_i[2:0];
			end
		end
	end

	// ==========================
	// sequencer
	assign conv_end = (state_reg == ADCC_DONE);
	assign sar_start = (state_reg == ADCC_SAMPLE);
	assign sar_step = (state_reg == ADCC_CONVERT) && (cnt_reg == 8'h00);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ADCC_IDLE: begin
				if (conv_enable_bit) begin
					state_next = ADCC_SAMPLE;
				end
			end
			ADCC_SAMPLE: begin
				if (cnt_reg == 8'h00) begin
					state_next = ADCC_CONVERT;
				end
			end
			ADCC_CONVERT: begin
				if (sar_step && sar_last) begin
					state_next = ADCC_DONE;
				end
			end
			ADCC_DONE: begin
				state_next = ADCC_SAMPLE;
			end
			default: begin
				state_next = ADCC_IDLE;
			end
		endcase
		// any control write cancels; enable decides whether it restarts
		if (ctrl_write) begin
			state_next = ADCC_IDLE;
		end
		if (standby_i || !conv_enable_bit) begin
			state_next = ADCC_IDLE;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= ADCC_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// the bit steps share what is left after sampling
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_reg <= '0;
			step_len_reg <= '0;
		end else if (state_next == ADCC_SAMPLE && state_reg != ADCC_SAMPLE) begin
			cnt_reg <= sample_len - 8'h01;
			step_len_reg <= ((conv_len - sample_len) >> 3) - 8'h01;
		end else if (state_next == ADCC_CONVERT && cnt_reg == 8'h00) begin
			cnt_reg <= step_len_reg;
		end else if (cnt_reg != 8'h00) begin
			cnt_reg <= cnt_reg - 8'h01;
		end
	end

	// first result after start is flagged as unusable
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			first_reg <= 1'b1;
		end else if (state_reg == ADCC_IDLE) begin
			first_reg <= 1'b1;
		end else if (conv_end && !ctrl_write) begin
			first_reg <= 1'b0;
		end
	end

	// ==========================
	// result store with collisions
	assign store_now = pending_valid_reg && !rd_result;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			conversion_result_reg <= '0;
			pending_reg <= '0;
			pending_valid_reg <= 1'b0;
		end else begin
			if (conv_end && !ctrl_write && !standby_i) begin
				pending_reg <= core.trial;
				pending_valid_reg <= 1'b1;
			end else if (store_now) begin
				pending_valid_reg <= 1'b0;
			end
			if (store_now) begin
				conversion_result_reg <= pending_reg;
			end
		end
	end

	// ==========================
	// status, mask and interrupt
	// set wins over the clear by a status read; mode writes leave the done flag alone
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status_reg <= '0;
		end else begin
			if (rd_status) begin
				status_reg <= '0;
			end
			if (conv_end && !ctrl_write && !standby_i) begin
				status_reg[ADCC_ST_DONE] <= 1'b1;
				status_reg[ADCC_ST_FIRST] <= first_reg;
			end
			if (conv_end && ctrl_write) begin
				status_reg[ADCC_ST_DROP] <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_reg <= 1'b0;
			done_irq_reg <= 1'b0;
		end else begin
			irq_reg <= |(status_next_f() & mask_reg);
			done_irq_reg <= conv_end && !ctrl_write && !standby_i;
		end
	end

	function automatic logic [2:0] status_next_f();
		status_next_f = status_reg;
	endfunction

	// ==========================
	// bus answer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			dat_reg <= '0;
		end else begin
			ack_reg <= bus_req;
			dat_reg <= '0;
			if (bus_req && !we_i) begin
				case (adr_i)
					{1'b0, ADCC_OFS_MODE}: dat_reg <= {24'h000000, converter_mode_reg};
					{1'b0, ADCC_OFS_SEL}: dat_reg <= {24'h000000, input_select_reg};
					{1'b0, ADCC_OFS_RESULT}: dat_reg <= {24'h000000, conversion_result_reg};
					{1'b0, ADCC_OFS_STATUS}: dat_reg <= {29'h0, status_reg};
					{1'b1, ADCC_OFS_MASK}: dat_reg <= {29'h0, mask_reg};
					default: dat_reg <= '0;
				endcase
			end
		end
	end

	// ==========================
	// core link
	assign core.sample = (state_reg == ADCC_SAMPLE);
	assign core.hold = (state_reg == ADCC_CONVERT);
	assign core.cmp_hi = cmp_hi_i;

	adcc_sar #(.NBITS(NBITS)) u_sar (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(sar_start),
		.step_i(sar_step),
		.cmp_hi_i(core.cmp_hi),
		.trial_o(core.trial),
		.last_o(sar_last)
	);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sample_reg <= 1'b0;
			trial_reg <= '0;
			sel_reg <= 1'b0;
		end else begin
			sample_reg <= core.sample;
			trial_reg <= core.trial;
			sel_reg <= input_select_reg[ADCC_SEL_BIT];
		end
	end

	assign dat_o = dat_reg;
	assign ack_o = ack_reg;
	assign irq_o = irq_reg;
	assign conversion_done_irq_o = done_irq_reg;
	assign sample_o = sample_reg;
	assign trial_o = trial_reg;
	assign analog_sel_o = sel_reg;

	// ==========================
	// checks
	sequence end_clean_s;
		conv_end && !ctrl_write && !standby_i;
	endsequence

	property done_sets_p;
		@(posedge clk_i) disable iff (rst_i) end_clean_s |=> status_reg[ADCC_ST_DONE];
	endproperty

	done_flag_set_a: assert property (done_sets_p) else $error("done flag not set");
	write_wins_a: assert property (@(posedge clk_i) disable iff (rst_i)
		conv_end && ctrl_write |=> !done_irq_reg) else $error("done raised on colliding write");
	read_first_a: assert property (@(posedge clk_i) disable iff (rst_i)
		pending_valid_reg && rd_result |=> $stable(conversion_result_reg)) else $error("result changed under read");
	standby_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
		standby_i |=> state_reg == ADCC_IDLE) else $error("converter ran in standby");
	mode_keeps_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_mode && status_reg[ADCC_ST_DONE] && !rd_status |=> status_reg[ADCC_ST_DONE])
		else $error("mode write cleared flag");
	repeat_conv_a: assert property (@(posedge clk_i) disable iff (rst_i)
		conv_end && !ctrl_write && !standby_i && conv_enable_bit |=> state_reg == ADCC_SAMPLE)
		else $error("no repeat");
	restart_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_mode && dat_i[ADCC_EN_BIT] && !standby_i |=> state_reg == ADCC_IDLE ##1 state_reg == ADCC_SAMPLE)
		else $error("no restart");
	first_mark_a: assert property (@(posedge clk_i) disable iff (rst_i)
		end_clean_s && first_reg |=> status_reg[ADCC_ST_FIRST] && !first_reg)
		else $error("first result unmarked");
endmodule

// File: tb/adcc_analog_model.sv
// Purpose: sample and hold plus comparator seen by the sequencer
// Assumes: analog level given as an ideal 8-bit code
// Notes: level is frozen while not sampling, as a real hold cap would
`timescale 1ns/1ps
module adcc_analog_model (
	// clock
	input wire logic clk_i,
	// from sequencer
	input wire logic sample_i,
	input wire logic [7:0] trial_i,
	// level at the pin
	input wire logic [7:0] vin_i,
	// comparator
	output logic cmp_hi_o
);
	// ==========================
	// hold and compare
	logic [7:0] held_reg = 8'h00;
	always_ff @(posedge clk_i) begin
		if (sample_i) begin
			held_reg <= vin_i;
		end
	end
	assign cmp_hi_o = (held_reg >= trial_i);
endmodule

// File: tb/adc_sequencing_conflict_ctrl_tb_top.sv
// Purpose: self-checking bench for the converter controller
// Assumes: wishbone classic, ack one cycle after strobe
// Notes: collision cycle found by sweeping offsets near completion
`timescale 1ns/1ps
module adc_sequencing_conflict_ctrl_tb_top;
	import adcc_pkg::*;
	// ==========================
	// signals
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic we_i = 1'b0;
	logic [4:0] adr_i = 5'h00;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0;
	logic standby_i = 1'b0;
	logic [7:0] vin = 8'hA5;
	logic [31:0] dat_o;
	logic ack_o, cmp_hi_i, sample_o, analog_sel_o, irq_o, conversion_done_irq_o;
	logic [7:0] trial_o;
	logic [31:0] seed = 32'h6;
	logic [2:0] codes [6] = '{ADCC_FR_72, ADCC_FR_60, ADCC_FR_48, ADCC_FR_144, ADCC_FR_120, ADCC_FR_96};
	int err_total = 0;
	int comparisons = 0;
	int cyc_n = 0;
	int done_cnt = 0;
	int last_done = 0;

	always #20 clk_i = ~clk_i;

	adcc_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
		.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .cmp_hi_i(cmp_hi_i), .sample_o(sample_o),
		.trial_o(trial_o), .analog_sel_o(analog_sel_o), .standby_i(standby_i), .irq_o(irq_o),
		.conversion_done_irq_o(conversion_done_irq_o));
	adcc_analog_model model (.clk_i(clk_i), .sample_i(sample_o), .trial_i(trial_o), .vin_i(vin),
		.cmp_hi_o(cmp_hi_i));

	// ==========================
	// helpers
	always @(posedge clk_i) begin
		cyc_n <= cyc_n + 1;
		if (conversion_done_irq_o === 1'b1) begin
			done_cnt <= done_cnt + 1;
			last_done <= cyc_n;
		end
	end

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic int exp_conv(input logic [2:0] fr);
		case (fr)
			ADCC_FR_72: return 72;
			ADCC_FR_60: return 60;
			ADCC_FR_48: return 48;
			ADCC_FR_120: return 120;
			ADCC_FR_96: return 96;
			default: return 144;
		endcase
	endfunction

	function automatic logic [31:0] mode_w(input logic [2:0] fr);
		return {24'h0, 1'b1, 1'b0, fr, 3'h0};
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH at %0t got %0h exp %0h", $time, got, exp);
		end
	endtask

	// held until ack is sampled, then released for one idle cycle
	task automatic wb(input logic we, input logic [4:0] adr, input logic [31:0] wd, output logic [31:0] rd);
		int n;
		n = 0;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= we;
		adr_i <= adr;
		dat_i <= wd;
		sel_i <= 4'hF;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 50);
		if (n >= 50) chk(32'h0, 32'h1);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic wait_done();
		int c0, n;
		c0 = done_cnt;
		n = 0;
		while (done_cnt == c0 && n < 1000) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 1000) chk(32'h0, 32'h1);
	endtask

	task automatic summarize();
		if (err_total == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// ==========================
	// watchdog, well beyond the expected five thousand cycles or so
	initial begin
		repeat (40000) @(posedge clk_i);
		err_total++;
		summarize();
	end

	// ==========================
	// scenarios
	initial begin
		logic [31:0] rd, rnd;
		int p, t, hits, c0, n, d;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		for (int a = 0; a < 6; a++) begin
			wb(1'b0, 5'(a * 4), 32'h0, rd);
			chk(rd, 32'h0);
		end
		wb(1'b1, {1'b0, ADCC_OFS_SEL}, 32'h1, rd);
		chk({31'h0, analog_sel_o}, 32'h1);
		wb(1'b1, 5'h00, mode_w(ADCC_FR_72), rd);
		wait_done();
		repeat (2) @(posedge clk_i);
		chk({31'h0, irq_o}, 32'h0);
		wb(1'b1, 5'h10, 32'h1, rd);
		@(posedge clk_i);
		chk({31'h0, irq_o}, 32'h1);
		wb(1'b0, {1'b0, ADCC_OFS_STATUS}, 32'h0, rd);
		chk(rd, 32'h3);
		@(posedge clk_i);
		chk({31'h0, irq_o}, 32'h0);
		wait_done();
		t = last_done;
		wb(1'b0, {1'b0, ADCC_OFS_STATUS}, 32'h0, rd);
		chk(rd, 32'h1);
		wb(1'b0, {1'b0, ADCC_OFS_RESULT}, 32'h0, rd);
		chk(rd, {24'h0, vin});
		wait_done();
		p = last_done - t;
		wb(1'b1, 5'h00, mode_w(ADCC_FR_72), rd);
		wb(1'b0, {1'b0, ADCC_OFS_STATUS}, 32'h0, rd);
		chk({31'h0, rd[ADCC_ST_DONE]}, 32'h1);
		// sweep request offsets across the completion cycle
		hits = 0;
		for (int k = 0; k < 16; k++) begin
			d = k >> 1;
			wait_done();
			wb(1'b0, {1'b0, ADCC_OFS_STATUS}, 32'h0, rd);
			while (cyc_n < last_done + p - d) @(posedge clk_i);
			c0 = done_cnt;
			wb(k[0], k[0] ? {1'b0, ADCC_OFS_SEL} : {1'b0, ADCC_OFS_RESULT}, 32'h1, rd);
			if (!k[0]) chk(rd, {24'h0, vin});
			repeat (2) @(posedge clk_i);
			wb(1'b0, {1'b0, ADCC_OFS_STATUS}, 32'h0, rd);
			if (!k[0]) chk({31'h0, rd[ADCC_ST_DROP]}, 32'h0);
			if (k[0] && rd[ADCC_ST_DROP] === 1'b1) begin
				hits++;
				chk(done_cnt, c0);
			end
		end
		chk(hits > 0, 32'h1);
		// corner and random levels, first result thrown away
		for (int i = 0; i < 8; i++) begin
			rnd = xs();
			vin <= (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : rnd[7:0];
			wb(1'b0, {1'b0, ADCC_OFS_STATUS}, 32'h0, rd);
			wb(1'b1, 5'h00, mode_w(codes[i % 6]), rd);
			wait_done();
			wait_done();
			wb(1'b0, {1'b0, ADCC_OFS_RESULT}, 32'h0, rd);
			chk(rd, {24'h0, vin});
		end
		// sampling share for every time selection
		for (int i = 0; i < 6; i++) begin
			wb(1'b1, 5'h00, mode_w(codes[i]), rd);
			n = 0;
			while (sample_o === 1'b1 && n < 300) begin @(posedge clk_i); n++; end
			n = 0;
			while (sample_o !== 1'b1 && n < 300) begin @(posedge clk_i); n++; end
			n = 0;
			while (sample_o === 1'b1 && n < 300) begin @(posedge clk_i); n++; end
			chk(n, exp_conv(codes[i]) / 10);
		end
		wb(1'b1, 5'h00, 32'h0, rd);
		c0 = done_cnt;
		repeat (300) @(posedge clk_i);
		chk(done_cnt, c0);
		chk({31'h0, sample_o}, 32'h0);
		wb(1'b1, 5'h00, mode_w(ADCC_FR_72), rd);
		standby_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		c0 = done_cnt;
		repeat (300) @(posedge clk_i);
		chk(done_cnt, c0);
		chk({31'h0, sample_o}, 32'h0);
		standby_i <= 1'b0;
		summarize();
	end
endmodule
